// ==== hdl/spp_cfg.svh ====
// Offsets, field positions, reset values and sizes of the port policy block
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH
// Register indices as printed; byte address is four times the index
`define SPP_IDX_QIDX        12'h900
`define SPP_IDX_WEIGHT      12'h915
`define SPP_IDX_DROP        12'ha00
`define SPP_IDX_MEMBER      12'ha04
`define SPP_IDX_POLICY      12'hb00
`define SPP_ADDR_W          14
// Field positions in the lookup policy register
`define SPP_POL_NULL_VID    7
`define SPP_POL_IN_FILT     6
`define SPP_POL_PORT_DEFAULT_VLAN_ID_ONLY   5
`define SPP_POL_MAC_AUTH    4
`define SPP_POL_SELF_FILT   3
`define SPP_POL_RSVD_RW     1
`define SPP_POL_RW_MASK     8'hfa
// Reset values
`define SPP_RST_WEIGHT      7'h01
`define SPP_RST_DROP        2'h0
`define SPP_RST_MEMBER      7'h7f
`define SPP_RST_POLICY      8'h00
`define SPP_RST_QIDX        2'h0
// Sizes
`define SPP_NQ              4
`define SPP_WGT_W           7
`define SPP_NPORT           7
`define SPP_VID_W           12
`define SPP_MAC_W           48
`endif

// ==== hdl/spp_pkg.sv ====
// Types shared by the port policy block
`include "spp_cfg.svh"
package spp_pkg;
  typedef logic [`SPP_WGT_W-1:0] spp_weight_t;
  typedef logic [1:0]            spp_qidx_t;
  typedef logic [`SPP_VID_W-1:0] spp_vid_t;
  typedef enum logic [1:0] {
    SPP_DROP_NONE = 2'h0,
    SPP_DROP_P0   = 2'h1,
    SPP_DROP_P01  = 2'h2,
    SPP_DROP_P012 = 2'h3
  } spp_drop_t;
endpackage

// ==== hdl/spp_wgt_if.sv ====
// Carrier between the register logic and the queue weight store
`timescale 1ns/1ns
`default_nettype none
interface spp_wgt_if;
  logic                 wr_en;
  spp_pkg::spp_qidx_t   wr_addr;
  spp_pkg::spp_weight_t wr_data;
  spp_pkg::spp_qidx_t   ra_addr;
  spp_pkg::spp_weight_t ra_data;
  spp_pkg::spp_qidx_t   rb_addr;
  spp_pkg::spp_weight_t rb_data;
  modport ctl (output wr_en, wr_addr, wr_data, ra_addr, rb_addr,
               input ra_data, rb_data);
  modport mem (input wr_en, wr_addr, wr_data, ra_addr, rb_addr,
               output ra_data, rb_data);
endinterface
`default_nettype wire

// ==== hdl/spp_wgt_mem.sv ====
// Banked queue weight store, one write port and two registered read ports
`timescale 1ns/1ns
`include "spp_cfg.svh"
`default_nettype none
module spp_wgt_mem (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Access
  spp_wgt_if.mem    wb
);
  spp_pkg::spp_weight_t mem_r [`SPP_NQ];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < `SPP_NQ; i++) begin
        mem_r[i] <= `SPP_RST_WEIGHT;
      end
    end else if (wb.wr_en) begin
      mem_r[wb.wr_addr] <= wb.wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb.ra_data <= `SPP_RST_WEIGHT;
      wb.rb_data <= `SPP_RST_WEIGHT;
    end else begin
      wb.ra_data <= mem_r[wb.ra_addr];
      wb.rb_data <= mem_r[wb.rb_addr];
    end
  end
endmodule
`default_nettype wire

// ==== hdl/spp_port_policy.sv ====
// Per-port policy registers with WRR service, drop and lookup decisions
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "spp_cfg.svh"
`default_nettype none
module spp_port_policy (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`SPP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  // Egress scheduler
  input  wire logic                  wrr_mode,
  input  wire logic                  single_queue,
  input  wire logic [`SPP_NQ-1:0]    queue_busy,
  input  wire logic                  pkt_sent,
  output logic [1:0]                 serve_queue,
  // Congestion
  input  wire logic                  frm_valid,
  input  wire logic [1:0]            frm_prio,
  input  wire logic                  dest_congested,
  output logic                       frm_drop,
  output logic                       flow_ctrl,
  // Forwarding and lookup
  output logic [`SPP_NPORT-1:0]      fwd_member,
  output logic                       mac_auth_en,
  input  wire logic                  rx_valid,
  input  wire logic                  rx_tagged,
  input  wire logic [`SPP_VID_W-1:0] rx_vid,
  input  wire logic [`SPP_VID_W-1:0] port_default_vlan_id,
  input  wire logic                  vlan_member_ok,
  input  wire logic [`SPP_MAC_W-1:0] rx_src_mac,
  input  wire logic [`SPP_MAC_W-1:0] switch_mac,
  input  wire logic                  glob_self_filt_en,
  output logic [`SPP_VID_W-1:0]      lookup_vid,
  output logic                       rx_discard
);

  // Byte address of a printed register index
  function automatic logic [`SPP_ADDR_W-1:0] reg_addr(input logic [11:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  spp_wgt_if wb ();

  spp_wgt_mem u_wgt (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wb      (wb)
  );

  spp_pkg::spp_qidx_t   qidx_r;
  spp_pkg::spp_drop_t   drop_r;
  logic [`SPP_NPORT-1:0] member_r;
  logic [7:0]           policy_r;
  logic                 acc_w;
  logic                 acc_r;
  logic                 hit_qidx;
  logic                 hit_wgt;
  logic                 hit_drop;
  logic                 hit_member;
  logic                 hit_policy;
  logic                 hit_any;
  logic [31:0]          rd_mux;

  // Access phase edge that completes the transfer, one wait state
  assign acc_w = psel & penable & pready & pwrite;
  assign acc_r = psel & penable & pready & ~pwrite;

  assign hit_qidx   = paddr == reg_addr(`SPP_IDX_QIDX);
  assign hit_wgt    = paddr == reg_addr(`SPP_IDX_WEIGHT);
  assign hit_drop   = paddr == reg_addr(`SPP_IDX_DROP);
  assign hit_member = paddr == reg_addr(`SPP_IDX_MEMBER);
  assign hit_policy = paddr == reg_addr(`SPP_IDX_POLICY);
  assign hit_any    = hit_qidx | hit_wgt | hit_drop | hit_member | hit_policy;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & penable & ~pready & ~hit_any;
    end
  end

  // Weight read port follows the index so data is ready by the answer edge
  assign wb.ra_addr = qidx_r;
  assign wb.wr_en   = acc_w & hit_wgt;
  assign wb.wr_addr = qidx_r;
  assign wb.wr_data = pwdata[`SPP_WGT_W-1:0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_qidx) begin
      rd_mux[1:0] = qidx_r;
    end
    if (hit_wgt) begin
      rd_mux[`SPP_WGT_W-1:0] = wb.ra_data;
    end
    if (hit_drop) begin
      rd_mux[1:0] = drop_r;
    end
    if (hit_member) begin
      rd_mux[`SPP_NPORT-1:0] = member_r;
    end
    if (hit_policy) begin
      rd_mux[7:0] = policy_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & penable & ~pready & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      qidx_r <= `SPP_RST_QIDX;
    end else if (acc_w & hit_qidx) begin
      qidx_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drop_r <= spp_pkg::spp_drop_t'(`SPP_RST_DROP);
    end else if (acc_w & hit_drop) begin
      drop_r <= spp_pkg::spp_drop_t'(pwdata[1:0]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      member_r <= `SPP_RST_MEMBER;
    end else if (acc_w & hit_member) begin
      member_r <= pwdata[`SPP_NPORT-1:0];
    end
  end

  // Reserved bits 2 and 0 never store; bit 1 is a plain scratch bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      policy_r <= `SPP_RST_POLICY;
    end else if (acc_w & hit_policy) begin
      policy_r <= pwdata[7:0] & `SPP_POL_RW_MASK;
    end
  end

  // Mask leaves straight from its register, no tag or table term in it
  assign fwd_member  = member_r;
  assign mac_auth_en = policy_r[`SPP_POL_MAC_AUTH];

  // Weighted round robin service
  logic [1:0]            q_r;
  logic [`SPP_WGT_W-1:0] cnt_r;
  logic [`SPP_WGT_W-1:0] wgt_eff;
  logic                  wrr_act;
  logic                  quota_done;
  logic [1:0]            q_next;

  // A zero weight would stall the queue forever; serve it as one
  assign wgt_eff = (wb.rb_data == '0) ? `SPP_RST_WEIGHT : wb.rb_data;
  assign wrr_act = wrr_mode & ~single_queue;
  assign quota_done = (cnt_r + 7'h01) >= wgt_eff;
  assign wb.rb_addr = q_r;

  always_comb begin
    q_next = q_r + 2'h1;
    for (int k = 3; k >= 1; k--) begin
      if (queue_busy[2'(q_r + 2'(k))]) begin
        q_next = 2'(q_r + 2'(k));
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_r   <= 2'h0;
      cnt_r <= '0;
    end else if (single_queue) begin
      q_r   <= 2'h0;
      cnt_r <= '0;
    end else if (wrr_act & pkt_sent) begin
      if (quota_done | ~queue_busy[q_r]) begin
        q_r   <= q_next;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 7'h01;
      end
    end else if (wrr_act & ~queue_busy[q_r] & (queue_busy != '0)) begin
      q_r   <= q_next;
      cnt_r <= '0;
    end
  end

  assign serve_queue = q_r;

  // Congestion drop and flow control
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frm_drop  <= 1'b0;
      flow_ctrl <= 1'b0;
    end else begin
      flow_ctrl <= dest_congested &
                   (drop_r == spp_pkg::SPP_DROP_NONE);
      frm_drop  <= frm_valid & dest_congested &
                   (drop_r != spp_pkg::SPP_DROP_NONE) &
                   (frm_prio < drop_r);
    end
  end

  // Ingress lookup
  logic [`SPP_VID_W-1:0] eff_vid;
  logic                  self_hit;

  always_comb begin
    eff_vid = rx_vid;
    if (~rx_tagged) begin
      eff_vid = port_default_vlan_id;
    end else if ((rx_vid == '0) & ~policy_r[`SPP_POL_NULL_VID]) begin
      eff_vid = port_default_vlan_id;
    end
  end

  assign self_hit = policy_r[`SPP_POL_SELF_FILT] & glob_self_filt_en &
                    (rx_src_mac == switch_mac);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lookup_vid <= '0;
      rx_discard <= 1'b0;
    end else if (rx_valid) begin
      lookup_vid <= eff_vid;
      rx_discard <= (policy_r[`SPP_POL_IN_FILT] & ~vlan_member_ok) |
                    (policy_r[`SPP_POL_PORT_DEFAULT_VLAN_ID_ONLY] &
                     (eff_vid != port_default_vlan_id)) |
                    self_hit;
    end else begin
      rx_discard <= 1'b0;
    end
  end

  // Checks
  property p_qidx_wr;
    @(posedge clk_sys) disable iff (rst)
      acc_w && hit_qidx |=> qidx_r == $past(pwdata[1:0]);
  endproperty
  a_qidx_wr: assert property (p_qidx_wr)
    else $error("queue index write lost");

  property p_wgt_bank;
    @(posedge clk_sys) disable iff (rst)
      acc_w && hit_wgt |=> ##1 (wb.ra_data == $past(pwdata[6:0], 2))
                               || (qidx_r != $past(qidx_r, 2));
  endproperty
  a_wgt_bank: assert property (p_wgt_bank)
    else $error("weight not written to selected queue");

  property p_wrr_quota;
    @(posedge clk_sys) disable iff (rst)
      wrr_act && pkt_sent && quota_done && !single_queue
        |=> cnt_r == '0;
  endproperty
  a_wrr_quota: assert property (p_wrr_quota)
    else $error("queue served past its weight");

  property p_single_q;
    @(posedge clk_sys) disable iff (rst)
      single_queue |=> serve_queue == 2'h0 && cnt_r == '0;
  endproperty
  a_single_q: assert property (p_single_q)
    else $error("single queue mode not on queue 0");

  property p_fc_nodrop;
    @(posedge clk_sys) disable iff (rst)
      dest_congested && drop_r == spp_pkg::SPP_DROP_NONE
        |=> flow_ctrl && !frm_drop;
  endproperty
  a_fc_nodrop: assert property (p_fc_nodrop)
    else $error("mode 00 must flow control and not drop");

  property p_drop_prio;
    @(posedge clk_sys) disable iff (rst)
      frm_valid && dest_congested && drop_r == spp_pkg::SPP_DROP_P01
        |=> !flow_ctrl && (frm_drop == ($past(frm_prio) <= 2'h1));
  endproperty
  a_drop_prio: assert property (p_drop_prio)
    else $error("mode 10 drop decision wrong");

  property p_member_wr;
    @(posedge clk_sys) disable iff (rst)
      acc_w && hit_member |=> fwd_member == $past(pwdata[6:0]);
  endproperty
  a_member_wr: assert property (p_member_wr)
    else $error("membership mask not updated");

  property p_null_vid;
    @(posedge clk_sys) disable iff (rst)
      rx_valid && rx_tagged && rx_vid == '0
        |=> lookup_vid == ($past(policy_r[`SPP_POL_NULL_VID]) ? '0
                           : $past(port_default_vlan_id));
  endproperty
  a_null_vid: assert property (p_null_vid)
    else $error("null VLAN ID lookup wrong");

  property p_self_filt;
    @(posedge clk_sys) disable iff (rst)
      rx_valid && rx_src_mac == switch_mac && policy_r[`SPP_POL_SELF_FILT] &&
        glob_self_filt_en |=> rx_discard;
  endproperty
  a_self_filt: assert property (p_self_filt)
    else $error("self address frame not dropped");

  property p_rsvd_zero;
    @(posedge clk_sys) disable iff (rst)
      pready && !pwrite && hit_policy |-> prdata[2] == 1'b0 &&
        prdata[0] == 1'b0 && prdata[31:8] == '0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved policy bits read nonzero");

  c_wrr_move: cover property (@(posedge clk_sys) disable iff (rst)
    wrr_act && pkt_sent && quota_done ##1 serve_queue != $past(q_r));
  c_drop: cover property (@(posedge clk_sys) disable iff (rst) frm_drop);
  c_discard: cover property (@(posedge clk_sys) disable iff (rst)
    rx_discard);
  c_wr_rd: cover property (@(posedge clk_sys) disable iff (rst)
    acc_w ##[1:4] acc_r);

endmodule
`default_nettype wire

// ==== bench/test_spp_port_policy.sv ====
// Self-checking bench for the per-port policy register block
`timescale 1ns/1ns
`include "spp_cfg.svh"
`default_nettype none
module test_spp_port_policy;
  localparam logic [13:0] A_QIDX = {`SPP_IDX_QIDX, 2'b00};
  localparam logic [13:0] A_WGT  = {`SPP_IDX_WEIGHT, 2'b00};
  localparam logic [13:0] A_DROP = {`SPP_IDX_DROP, 2'b00};
  localparam logic [13:0] A_MEMB = {`SPP_IDX_MEMBER, 2'b00};
  localparam logic [13:0] A_POL  = {`SPP_IDX_POLICY, 2'b00};
  localparam logic [13:0] A_BAD  = 14'h2404;
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [13:0] paddr     = 14'h0;
  logic [31:0] pwdata    = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        wrr_mode  = 1'b1;
  logic        single_queue = 1'b0;
  logic [3:0]  queue_busy = 4'hf;
  logic        pkt_sent  = 1'b0;
  logic [1:0]  serve_queue;
  logic        frm_valid = 1'b0;
  logic [1:0]  frm_prio  = 2'h0;
  logic        dest_congested = 1'b0;
  logic        frm_drop;
  logic        flow_ctrl;
  logic [6:0]  fwd_member;
  logic        mac_auth_en;
  logic        rx_valid  = 1'b0;
  logic        rx_tagged = 1'b0;
  logic [11:0] rx_vid    = 12'h0;
  logic [11:0] port_default_vlan_id = 12'h1;
  logic        vlan_member_ok = 1'b1;
  logic [47:0] rx_src_mac = 48'h0;
  logic [47:0] switch_mac = 48'h0000_0000_0a5c;
  logic        glob_self_filt_en = 1'b0;
  logic [11:0] lookup_vid;
  logic        rx_discard;
  integer      n_fail    = 0;
  integer      cmp_count = 0;
  integer      seed      = 96;
  integer      wgt[4];
  logic [31:0] rd;
  logic        err;

  always #4 clk_sys = ~clk_sys;

  spp_port_policy spp_port_policy_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .wrr_mode(wrr_mode),
    .single_queue(single_queue), .queue_busy(queue_busy),
    .pkt_sent(pkt_sent), .serve_queue(serve_queue),
    .frm_valid(frm_valid), .frm_prio(frm_prio),
    .dest_congested(dest_congested), .frm_drop(frm_drop),
    .flow_ctrl(flow_ctrl), .fwd_member(fwd_member),
    .mac_auth_en(mac_auth_en), .rx_valid(rx_valid),
    .rx_tagged(rx_tagged), .rx_vid(rx_vid),
    .port_default_vlan_id(port_default_vlan_id),
    .vlan_member_ok(vlan_member_ok), .rx_src_mac(rx_src_mac),
    .switch_mac(switch_mac), .glob_self_filt_en(glob_self_filt_en),
    .lookup_vid(lookup_vid), .rx_discard(rx_discard)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("Error at %0t: no pready", $time);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, err}, 32'h0);
  endtask

  task automatic pulse_pkt;
    @(posedge clk_sys);
    pkt_sent <= 1'b1;
    @(posedge clk_sys);
    pkt_sent <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    logic [1:0]  cur;
    logic [7:0]  pol;
    logic [11:0] ev;
    logic        ed;
    logic [6:0]  m;
    integer      r;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check({25'h0, fwd_member}, 32'h7f);
    check({31'h0, mac_auth_en}, 32'h0);
    check({30'h0, serve_queue}, 32'h0);
    rd_chk(A_QIDX, 32'h0);
    rd_chk(A_WGT, 32'h1);
    rd_chk(A_DROP, 32'h0);
    rd_chk(A_MEMB, 32'h7f);
    rd_chk(A_POL, 32'h0);
    apb(1'b1, A_BAD, 32'hffff_ffff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, A_BAD, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Banked weights, small so the rotation stays short; bit 7 is reserved
    for (int q = 0; q < 4; q++) begin
      wgt[q] = 1 + ($random(seed) & 3);
      apb(1'b1, A_QIDX, 32'hffff_fffc | q);
      apb(1'b1, A_WGT, 32'hffff_ff80 | wgt[q]);
    end
    for (int q = 3; q >= 0; q--) begin
      apb(1'b1, A_QIDX, q);
      rd_chk(A_QIDX, q);
      rd_chk(A_WGT, wgt[q]);
    end
    // Rotation: service moves on exactly after weight packets
    for (int k = 0; k < 8; k++) begin
      cur = serve_queue;
      for (int j = 1; j <= wgt[cur]; j++) begin
        pulse_pkt();
        check({31'h0, serve_queue != cur}, {31'h0, j == wgt[cur]});
      end
    end
    // Outside WRR the service pointer holds however many packets go out
    @(posedge clk_sys);
    wrr_mode <= 1'b0;
    cur = serve_queue;
    for (int k = 0; k < 3; k++) begin
      pulse_pkt();
      check({30'h0, serve_queue}, {30'h0, cur});
    end
    @(posedge clk_sys);
    wrr_mode     <= 1'b1;
    single_queue <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < 6; k++) begin
      pulse_pkt();
      check({30'h0, serve_queue}, 32'h0);
    end
    // Every drop mode against every priority, congested and not
    for (int md = 0; md < 4; md++) begin
      apb(1'b1, A_DROP, 32'hffff_fffc | md);
      rd_chk(A_DROP, md);
      for (int c = 0; c < 8; c++) begin
        @(posedge clk_sys);
        frm_valid      <= 1'b1;
        frm_prio       <= c[1:0];
        dest_congested <= c[2];
        @(posedge clk_sys);
        frm_valid <= 1'b0;
        #1;
        check({31'h0, frm_drop}, {31'h0, c[2] && c[1:0] < md});
        check({31'h0, flow_ctrl}, {31'h0, c[2] && md == 0});
      end
    end
    @(posedge clk_sys);
    dest_congested <= 1'b0;
    m = 7'($random(seed));
    apb(1'b1, A_MEMB, {25'h1ff_ffff, m});
    rd_chk(A_MEMB, {25'h0, m});
    apb(1'b1, A_POL, 32'hffff_ffff);
    rd_chk(A_POL, 32'hfa);
    // Lookup policies with random frames, the model decides each result
    for (int p = 0; p < 16; p++) begin
      pol = 8'($random(seed)) & 8'hf8;
      apb(1'b1, A_POL, {24'h0, pol});
      rd_chk(A_POL, {24'h0, pol});
      check({31'h0, mac_auth_en}, {31'h0, pol[4]});
      for (int f = 0; f < 6; f++) begin
        r = $random(seed);
        @(posedge clk_sys);
        rx_valid             <= 1'b1;
        rx_tagged            <= r[0];
        rx_vid               <= {10'h0, r[2:1]};
        port_default_vlan_id <= {11'h0, r[3]} + 12'h1;
        vlan_member_ok       <= r[4];
        glob_self_filt_en    <= r[5];
        rx_src_mac           <= r[6] ? switch_mac : ~switch_mac;
        if (!r[0] || (r[2:1] == 0 && !pol[7]))
          ev = {11'h0, r[3]} + 12'h1;
        else
          ev = {10'h0, r[2:1]};
        ed = (pol[6] && !r[4]) || (pol[5] && ev != {11'h0, r[3]} + 12'h1)
             || (pol[3] && r[5] && r[6]);
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        #1;
        check({20'h0, lookup_vid}, {20'h0, ev});
        check({31'h0, rx_discard}, {31'h0, ed});
        check({25'h0, fwd_member}, {25'h0, m});
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
